// *** rtl/frac_pkg.sv ***
// Package for the fractional payload controller: register map, fields, types
package frac_pkg;
    localparam int unsigned CNT_W          = 13;
    localparam logic [31:0] TX_CTRL_OFS    = 32'h0000_0000;
    localparam logic [31:0] RX_CTRL_OFS    = 32'h0000_0004;
    localparam logic [31:0] TX_GROUP_OFS   = 32'h0000_0008;
    localparam logic [31:0] TX_PARTA_OFS   = 32'h0000_000c;
    localparam logic [31:0] RX_GROUP_OFS   = 32'h0000_0010;
    localparam logic [31:0] RX_PARTA_OFS   = 32'h0000_0014;
    localparam logic [31:0] STATUS_OFS     = 32'h0000_0018;
    // Control fields
    localparam int unsigned CTRL_INT_BIT   = 0;
    localparam int unsigned CTRL_SEL_BIT   = 1;
    localparam int unsigned CTRL_SRC_LSB   = 2;
    localparam logic [CNT_W-1:0] GROUP_RST = 13'h0008;
    localparam logic [CNT_W-1:0] PARTA_RST = 13'h0000;
    localparam logic [31:0] BAD_ADDR_DATA  = 32'h0000_0000;

    typedef enum logic [1:0] {
        SRC_ZEROS = 2'h0,
        SRC_ONES  = 2'h1,
        SRC_ALT   = 2'h2,
        SRC_PIN   = 2'h3
    } ovh_src_e;

    // Per-direction configuration
    typedef struct packed {
        logic             internal_mode;
        logic             section_select;
        ovh_src_e         src;
        logic [CNT_W-1:0] group_len;
        logic [CNT_W-1:0] parta_len;
    } dir_cfg_s;

    // Per-direction counter state
    typedef struct packed {
        logic [CNT_W-1:0] pos;
        logic [CNT_W-1:0] group_len;
        logic [CNT_W-1:0] parta_len;
        logic             section_select;
        logic             internal_mode;
    } dir_cnt_s;

    typedef struct packed {
        dir_cfg_s   tx_cfg;
        dir_cfg_s   rx_cfg;
        dir_cnt_s   tx_cnt;
        dir_cnt_s   rx_cnt;
        logic       alt_bit;
        logic       tx_ovh_enable;
        logic       tx_data;
        logic       rx_ovh_enable;
        logic       rx_serial_ovh;
        logic       rx_payload;
        logic       rx_payload_valid;
        logic [31:0] prdata;
    } state_s;
endpackage : frac_pkg

// *** rtl/fractional_payload_controller.sv ***
// Fractional payload controller: overhead marking, insertion, extraction, APB registers
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Internal transmit mode drives tx overhead enable to mark inserted overhead.
// - Transmit groups are programmable from 1 to 8191 bits.
// - Transmit part A is programmable from 0 to 8191 bits.
// - Part B is the remainder of the group after part A.
// - Transmit section select picks part A or part B as overhead.
// - Tx overhead enable high in overhead part, low in payload part.
// - Tx overhead enable forced low during line overhead or stuff.
// - Rx overhead enable input sampled on the receive clock rising edge.
// - Rx overhead enable output changes only on the receive clock rising edge.
// - Internal receive mode marks overhead bits, low for payload and stuff.
// - Marked receive overhead bits are steered to the serial overhead output.
// - Receive groups 1 to 8191 bits, part A 0 to 8191 bits.
// - Receive section select picks part A or part B as overhead.
// - Rx overhead enable high in overhead part, low in payload part.
// - Rx overhead enable held low during line overhead or stuff.
// - Group counter restarts at every frame start.
// - Final group of a frame may be short.
// - Short group ends on last data bit before next frame start.
// - External tx mode: input marks overhead, device output held low.
// - Internal tx mode ignores the tx overhead enable input.
// - Tx overhead source: zeros, ones, alternating, or serial overhead pin.
// - Receive payload goes to packet side, overhead to serial output.
module fractional_payload_controller (
    // Clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        reset_in,
    // APB slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [31:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    input  wire logic [3:0]  pstrb_in,
    output logic             pready_out,
    output logic             pslverr_out,
    output logic [31:0]      prdata_out,
    // Transmit side
    input  wire logic        tx_clock_in,
    input  wire logic        tx_sof_in,
    input  wire logic        tx_line_ovh_in,
    input  wire logic        tx_payload_in,
    input  wire logic        tx_ovh_enable_in,
    input  wire logic        tx_serial_ovh_in,
    output logic             tx_ovh_enable_out,
    output logic             tx_data_out,
    // Receive side
    input  wire logic        rx_clock_out_en_in,
    input  wire logic        rx_sof_in,
    input  wire logic        rx_line_ovh_in,
    input  wire logic        rx_serial_data_in,
    input  wire logic        rx_ovh_enable_in,
    output logic             rx_ovh_enable_out,
    output logic             rx_serial_ovh_out,
    output logic             rx_payload_out,
    output logic             rx_payload_valid_out
);

    frac_pkg::state_s state_r;
    frac_pkg::state_s state_nxt;

    // Helpers shared by both directions
    // Part B is whatever follows part A
    function automatic logic in_ovh_part(input frac_pkg::dir_cnt_s c);
        logic in_a;
        in_a = (c.pos < c.parta_len);
        return c.section_select ? !in_a : in_a;
    endfunction

    function automatic frac_pkg::dir_cnt_s advance(input frac_pkg::dir_cnt_s c,
                                                   input frac_pkg::dir_cfg_s cfg,
                                                   input logic sof,
                                                   input logic data_bit);
        frac_pkg::dir_cnt_s n;
        logic [frac_pkg::CNT_W-1:0] last;
        n = c;
        last = c.group_len - 13'h0001;
        if (sof) begin
            // Fresh group at frame start; config other than the tx overhead source takes effect here only
            n.pos            = 13'h0001;
            n.group_len      = cfg.group_len;
            n.parta_len      = cfg.parta_len;
            n.section_select = cfg.section_select;
            n.internal_mode  = cfg.internal_mode;
            if (cfg.group_len == 13'h0001) begin
                n.pos = 13'h0000;
            end
        end else if (data_bit) begin
            // Wraps per group; short last group simply cut by next sof
            n.pos = (c.pos >= last) ? 13'h0000 : c.pos + 13'h0001;
        end
        return n;
    endfunction

    // Position of the current bit within its group, sof resets to zero
    function automatic frac_pkg::dir_cnt_s cur_view(input frac_pkg::dir_cnt_s c,
                                                    input frac_pkg::dir_cfg_s cfg,
                                                    input logic sof);
        frac_pkg::dir_cnt_s v;
        v = c;
        if (sof) begin
            v.pos            = 13'h0000;
            v.group_len      = cfg.group_len;
            v.parta_len      = cfg.parta_len;
            v.section_select = cfg.section_select;
            v.internal_mode  = cfg.internal_mode;
        end
        return v;
    endfunction

    logic               apb_setup;
    logic               apb_wr;
    logic               apb_rd;
    logic               addr_ok;
    logic               tx_ovh_bit;
    logic               rx_ovh_bit;
    logic               tx_src_bit;
    frac_pkg::dir_cnt_s tx_view;
    frac_pkg::dir_cnt_s rx_view;

    assign apb_setup = psel_in && !penable_in;
    assign apb_wr    = psel_in && penable_in && pwrite_in;
    assign apb_rd    = psel_in && !penable_in && !pwrite_in;
    assign addr_ok   = (paddr_in == frac_pkg::TX_CTRL_OFS)  ||
                       (paddr_in == frac_pkg::RX_CTRL_OFS)  ||
                       (paddr_in == frac_pkg::TX_GROUP_OFS) ||
                       (paddr_in == frac_pkg::TX_PARTA_OFS) ||
                       (paddr_in == frac_pkg::RX_GROUP_OFS) ||
                       (paddr_in == frac_pkg::RX_PARTA_OFS) ||
                       (paddr_in == frac_pkg::STATUS_OFS);

    assign tx_view = cur_view(state_r.tx_cnt, state_r.tx_cfg, tx_sof_in);
    assign rx_view = cur_view(state_r.rx_cnt, state_r.rx_cfg, rx_sof_in);

    always_comb begin
        state_nxt = state_r;
        tx_ovh_bit = 1'b0;
        rx_ovh_bit = 1'b0;
        tx_src_bit = 1'b0;

        // APB register writes, gated as a whole by the low strobe bit only
        if (apb_wr && pstrb_in[0]) begin
            unique case (paddr_in)
                frac_pkg::TX_CTRL_OFS: begin
                    state_nxt.tx_cfg.internal_mode  = pwdata_in[frac_pkg::CTRL_INT_BIT];
                    state_nxt.tx_cfg.section_select = pwdata_in[frac_pkg::CTRL_SEL_BIT];
                    state_nxt.tx_cfg.src = frac_pkg::ovh_src_e'(
                        pwdata_in[frac_pkg::CTRL_SRC_LSB +: 2]);
                end
                frac_pkg::RX_CTRL_OFS: begin
                    state_nxt.rx_cfg.internal_mode  = pwdata_in[frac_pkg::CTRL_INT_BIT];
                    state_nxt.rx_cfg.section_select = pwdata_in[frac_pkg::CTRL_SEL_BIT];
                end
                frac_pkg::TX_GROUP_OFS: begin
                    if (pwdata_in[12:0] != 13'h0000) begin
                        state_nxt.tx_cfg.group_len = pwdata_in[12:0];
                    end
                end
                frac_pkg::TX_PARTA_OFS: state_nxt.tx_cfg.parta_len = pwdata_in[12:0];
                frac_pkg::RX_GROUP_OFS: begin
                    if (pwdata_in[12:0] != 13'h0000) begin
                        state_nxt.rx_cfg.group_len = pwdata_in[12:0];
                    end
                end
                frac_pkg::RX_PARTA_OFS: state_nxt.rx_cfg.parta_len = pwdata_in[12:0];
                default: ;
            endcase
        end

        // Read data captured in setup so it is a flop at the access edge
        if (apb_rd) begin
            unique case (paddr_in)
                frac_pkg::TX_CTRL_OFS: state_nxt.prdata = {28'h0, state_r.tx_cfg.src,
                    state_r.tx_cfg.section_select, state_r.tx_cfg.internal_mode};
                frac_pkg::RX_CTRL_OFS: state_nxt.prdata = {30'h0,
                    state_r.rx_cfg.section_select, state_r.rx_cfg.internal_mode};
                frac_pkg::TX_GROUP_OFS: state_nxt.prdata = {19'h0, state_r.tx_cfg.group_len};
                frac_pkg::TX_PARTA_OFS: state_nxt.prdata = {19'h0, state_r.tx_cfg.parta_len};
                frac_pkg::RX_GROUP_OFS: state_nxt.prdata = {19'h0, state_r.rx_cfg.group_len};
                frac_pkg::RX_PARTA_OFS: state_nxt.prdata = {19'h0, state_r.rx_cfg.parta_len};
                frac_pkg::STATUS_OFS: state_nxt.prdata = {state_r.rx_cnt.pos, 3'h0,
                    state_r.tx_cnt.pos, 1'b0, state_r.rx_ovh_enable, state_r.tx_ovh_enable};
                default: state_nxt.prdata = frac_pkg::BAD_ADDR_DATA;
            endcase
        end

        // Transmit path, one step per transmit bit enable
        if (tx_clock_in) begin
            // Never in line overhead or stuff
            tx_ovh_bit = tx_view.internal_mode ? (in_ovh_part(tx_view) && !tx_line_ovh_in)
                                               : (tx_ovh_enable_in && !tx_line_ovh_in);
            unique case (state_r.tx_cfg.src)
                frac_pkg::SRC_ZEROS: tx_src_bit = 1'b0;
                frac_pkg::SRC_ONES:  tx_src_bit = 1'b1;
                frac_pkg::SRC_ALT:   tx_src_bit = state_r.alt_bit;
                frac_pkg::SRC_PIN:   tx_src_bit = tx_serial_ovh_in;
            endcase
            if (tx_ovh_bit) begin
                state_nxt.alt_bit = !state_r.alt_bit;
            end
            state_nxt.tx_ovh_enable = tx_view.internal_mode && tx_ovh_bit;
            state_nxt.tx_data = tx_ovh_bit ? tx_src_bit : tx_payload_in;
            state_nxt.tx_cnt = advance(state_r.tx_cnt, state_r.tx_cfg, tx_sof_in,
                                       !tx_line_ovh_in);
        end

        // Receive path on receive clock enable; payload valid pulse cleared on every clock
        state_nxt.rx_payload_valid = 1'b0;
        if (rx_clock_out_en_in) begin
            rx_ovh_bit = rx_view.internal_mode ? (in_ovh_part(rx_view) && !rx_line_ovh_in)
                                               : rx_ovh_enable_in;
            state_nxt.rx_ovh_enable = rx_view.internal_mode && rx_ovh_bit;
            if (rx_ovh_bit) begin
                state_nxt.rx_serial_ovh = rx_serial_data_in;
            end else if (!rx_line_ovh_in) begin
                state_nxt.rx_payload       = rx_serial_data_in;
                state_nxt.rx_payload_valid = 1'b1;
            end
            state_nxt.rx_cnt = advance(state_r.rx_cnt, state_r.rx_cfg, rx_sof_in,
                                       !rx_line_ovh_in);
        end
    end

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_r <= '{
                tx_cfg: '{internal_mode: 1'b0, section_select: 1'b0,
                          src: frac_pkg::SRC_ZEROS, group_len: frac_pkg::GROUP_RST,
                          parta_len: frac_pkg::PARTA_RST},
                rx_cfg: '{internal_mode: 1'b0, section_select: 1'b0,
                          src: frac_pkg::SRC_ZEROS, group_len: frac_pkg::GROUP_RST,
                          parta_len: frac_pkg::PARTA_RST},
                tx_cnt: '{pos: 13'h0000, group_len: frac_pkg::GROUP_RST,
                          parta_len: frac_pkg::PARTA_RST, section_select: 1'b0,
                          internal_mode: 1'b0},
                rx_cnt: '{pos: 13'h0000, group_len: frac_pkg::GROUP_RST,
                          parta_len: frac_pkg::PARTA_RST, section_select: 1'b0,
                          internal_mode: 1'b0},
                alt_bit: 1'b1,
                default: '0};
        end else begin
            state_r <= state_nxt;
        end
    end

    // APB answer: zero wait states, error on unmapped address
    assign pready_out           = 1'b1;
    assign pslverr_out          = psel_in && penable_in && !addr_ok;
    assign prdata_out           = state_r.prdata;
    assign tx_ovh_enable_out    = state_r.tx_ovh_enable;
    assign tx_data_out          = state_r.tx_data;
    assign rx_ovh_enable_out    = state_r.rx_ovh_enable;
    assign rx_serial_ovh_out    = state_r.rx_serial_ovh;
    assign rx_payload_out       = state_r.rx_payload;
    assign rx_payload_valid_out = state_r.rx_payload_valid;

    // Assertions
    property p_tx_stuff_low;
        @(posedge ref_clk_in) disable iff (reset_in)
        (tx_clock_in && tx_line_ovh_in) |=> !tx_ovh_enable_out;
    endproperty
    a_tx_stuff_low: assert property (p_tx_stuff_low) else $error("tx enable in stuff");

    property p_rx_stuff_low;
        @(posedge ref_clk_in) disable iff (reset_in)
        (rx_clock_out_en_in && rx_line_ovh_in) |=> !rx_ovh_enable_out;
    endproperty
    a_rx_stuff_low: assert property (p_rx_stuff_low) else $error("rx enable in stuff");

    property p_tx_ext_low;
        @(posedge ref_clk_in) disable iff (reset_in)
        (tx_clock_in && !tx_view.internal_mode) |=> !tx_ovh_enable_out;
    endproperty
    a_tx_ext_low: assert property (p_tx_ext_low) else $error("tx enable in external");

    property p_rx_hold;
        @(posedge ref_clk_in) disable iff (reset_in)
        !rx_clock_out_en_in |=> $stable(rx_ovh_enable_out);
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("rx enable moved off edge");

    property p_tx_sof_first;
        @(posedge ref_clk_in) disable iff (reset_in)
        (tx_clock_in && tx_sof_in && !tx_line_ovh_in && tx_view.internal_mode
         && tx_view.parta_len != 13'h0000)
        |=> (tx_ovh_enable_out == !$past(tx_view.section_select));
    endproperty
    a_tx_sof_first: assert property (p_tx_sof_first) else $error("frame start not group");

    property p_rx_steer;
        @(posedge ref_clk_in) disable iff (reset_in)
        (rx_clock_out_en_in && rx_view.internal_mode && in_ovh_part(rx_view)
         && !rx_line_ovh_in) |=> (rx_ovh_enable_out && rx_serial_ovh_out
                                  == $past(rx_serial_data_in));
    endproperty
    a_rx_steer: assert property (p_rx_steer) else $error("rx overhead not steered");

    property p_tx_ones;
        @(posedge ref_clk_in) disable iff (reset_in)
        (tx_clock_in && tx_ovh_bit && state_r.tx_cfg.src == frac_pkg::SRC_ONES)
        |=> tx_data_out;
    endproperty
    a_tx_ones: assert property (p_tx_ones) else $error("ones source wrong");

    sequence s_rx_pay_taken;
        rx_clock_out_en_in && !rx_ovh_bit && !rx_line_ovh_in;
    endsequence

    property p_rx_payload;
        @(posedge ref_clk_in) disable iff (reset_in)
        s_rx_pay_taken
        |=> (rx_payload_valid_out && rx_payload_out == $past(rx_serial_data_in));
    endproperty
    a_rx_payload: assert property (p_rx_payload) else $error("payload not forwarded");

    property p_rx_pulse;
        @(posedge ref_clk_in) disable iff (reset_in)
        !rx_clock_out_en_in
        |=> !rx_payload_valid_out;
    endproperty
    a_rx_pulse: assert property (p_rx_pulse) else $error("valid not a pulse");

    property p_rx_ext_low;
        @(posedge ref_clk_in) disable iff (reset_in)
        (rx_clock_out_en_in && !rx_view.internal_mode)
        |=> !rx_ovh_enable_out;
    endproperty
    a_rx_ext_low: assert property (p_rx_ext_low) else $error("rx enable in external");

    property p_tx_pay;
        @(posedge ref_clk_in) disable iff (reset_in)
        (tx_clock_in && !tx_ovh_bit)
        |=> (tx_data_out == $past(tx_payload_in));
    endproperty
    a_tx_pay: assert property (p_tx_pay) else $error("tx payload lost");

    property p_tx_pin;
        @(posedge ref_clk_in) disable iff (reset_in)
        (tx_clock_in && tx_ovh_bit && state_r.tx_cfg.src == frac_pkg::SRC_PIN)
        |=> (tx_data_out == $past(tx_serial_ovh_in));
    endproperty
    a_tx_pin: assert property (p_tx_pin) else $error("pin source wrong");

    property p_tx_zeros;
        @(posedge ref_clk_in) disable iff (reset_in)
        (tx_clock_in && tx_ovh_bit && state_r.tx_cfg.src == frac_pkg::SRC_ZEROS)
        |=> !tx_data_out;
    endproperty
    a_tx_zeros: assert property (p_tx_zeros) else $error("zeros source wrong");

endmodule : fractional_payload_controller

`default_nettype wire

// *** dv/line_stream_model.sv ***
// Far-side framer model: bit periods, frame starts, stuff periods, serial data
`timescale 1ns/100ps
`default_nettype none
module line_stream_model (
    // Clock and reset
    input  wire logic ref_clk_in,
    input  wire logic reset_in,
    // Control from the bench
    input  wire logic run_in,
    input  wire logic slow_in,
    // Stream toward the controller
    output logic      en_out,
    output logic      sof_out,
    output logic      lo_out,
    output logic      tx_pay_out,
    output logic      tx_oh_en_out,
    output logic      tx_oh_bit_out,
    output logic      rx_data_out,
    output logic      rx_oh_en_out
);
    logic [4:0] idx_r;
    logic [1:0] div_r;
    logic [7:0] seq_r;
    logic       stuff;

    // Frame of 23 periods, two of them stuff
    assign stuff = (idx_r == 5'h07) || (idx_r == 5'h0f);

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            {en_out, sof_out, lo_out, tx_pay_out, tx_oh_en_out} <= '0;
            {tx_oh_bit_out, rx_data_out, rx_oh_en_out, idx_r, div_r, seq_r} <= '0;
        end else if (run_in && div_r == 2'h0) begin
            en_out <= 1'b1;
            sof_out <= (idx_r == 5'h00);
            lo_out <= stuff;
            tx_pay_out <= seq_r[3];
            tx_oh_bit_out <= seq_r[5];
            rx_data_out <= seq_r[6];
            tx_oh_en_out <= (idx_r % 3 == 2) && !stuff;
            rx_oh_en_out <= (idx_r % 3 == 1) && !stuff;
            seq_r <= seq_r + 8'h1b;
            idx_r <= (idx_r == 5'h16) ? 5'h00 : idx_r + 5'h01;
            div_r <= slow_in ? 2'h1 : 2'h0;
        end else begin
            // Lines turn over between bit periods so a stale value is never reused
            en_out <= 1'b0;
            tx_pay_out <= ~tx_pay_out;
            tx_oh_bit_out <= ~tx_oh_bit_out;
            rx_data_out <= ~rx_data_out;
            div_r <= (div_r == 2'h2 || !run_in) ? 2'h0 : div_r + 2'h1;
            if (!run_in)
                idx_r <= 5'h00;
        end
    end
endmodule // line_stream_model
`default_nettype wire

// *** dv/fractional_payload_controller_tb.sv ***
// Self-checking bench for the fractional payload controller
`timescale 1ns/100ps
`default_nettype none
module fractional_payload_controller_tb;
    logic        ref_clk_in, reset_in, psel, penable, pwrite, run, slow, chk_on;
    logic [31:0] paddr, pwdata, rd;
    logic        pready_out, pslverr_out, err;
    logic [31:0] prdata_out;
    logic        en, sof, lo, tpay, toe, tob, rsd, roe;
    logic        tx_ovh_enable_out, tx_data_out, rx_ovh_enable_out;
    logic        rx_serial_ovh_out, rx_payload_out, rx_payload_valid_out;
    logic        te_e, td_e, td_chk, re_e, ro_e, vld_e, rp_e;
    logic [3:0]  tsh_c, rsh_c, tc, rc;
    logic [12:0] tsh_g, tsh_a, rsh_g, rsh_a, tg, ta, rg, ra, tp, rp;
    logic        alt, tgen, rgen, tov, rov, s;
    int          failures, n_tests, tno;
    logic [31:0] ofs [6] = '{frac_pkg::TX_CTRL_OFS, frac_pkg::RX_CTRL_OFS,
        frac_pkg::TX_GROUP_OFS, frac_pkg::TX_PARTA_OFS, frac_pkg::RX_GROUP_OFS,
        frac_pkg::RX_PARTA_OFS};

    fractional_payload_controller dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .pstrb_in(4'hf), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .prdata_out(prdata_out), .tx_clock_in(en),
        .tx_sof_in(sof), .tx_line_ovh_in(lo), .tx_payload_in(tpay),
        .tx_ovh_enable_in(toe), .tx_serial_ovh_in(tob), .tx_ovh_enable_out(tx_ovh_enable_out),
        .tx_data_out(tx_data_out), .rx_clock_out_en_in(en), .rx_sof_in(sof),
        .rx_line_ovh_in(lo), .rx_serial_data_in(rsd), .rx_ovh_enable_in(roe),
        .rx_ovh_enable_out(rx_ovh_enable_out), .rx_serial_ovh_out(rx_serial_ovh_out),
        .rx_payload_out(rx_payload_out), .rx_payload_valid_out(rx_payload_valid_out));

    line_stream_model far (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .run_in(run),
        .slow_in(slow), .en_out(en), .sof_out(sof), .lo_out(lo), .tx_pay_out(tpay),
        .tx_oh_en_out(toe), .tx_oh_bit_out(tob), .rx_data_out(rsd), .rx_oh_en_out(roe));

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk1(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk_in);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        if (pready_out !== 1'b1) begin
            failures++;
            $display("unexpected pready timeout expected 1 seen 0");
        end
        rd = prdata_out;
        err = pslverr_out;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk_in);
    endtask

    // Config is written with the stream stopped; the next frame start applies it
    task automatic run_cfg(input logic [3:0] t_c, input logic [3:0] r_c,
        input logic [12:0] t_g, input logic [12:0] t_a, input logic [12:0] r_g,
        input logic [12:0] r_a, input logic slw);
        logic [31:0] v [6];
        v = '{{28'h0, t_c}, {28'h0, r_c}, {19'h0, t_g}, {19'h0, t_a}, {19'h0, r_g},
            {19'h0, r_a}};
        for (int i = 0; i < 6; i++)
            apb(1'b1, ofs[i], v[i]);
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, ofs[i], 32'h0);
            chk32("register readback", v[i], rd);
        end
        {tsh_c, rsh_c, tsh_g, tsh_a, rsh_g, rsh_a} = {t_c, r_c, t_g, t_a, r_g, r_a};
        slow <= slw;
        run <= 1'b1;
        repeat (300) @(posedge ref_clk_in);
        run <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
        apb(1'b0, frac_pkg::STATUS_OFS, 32'h0);
        chk32("status", {rp, 3'h0, tp, 1'b0, re_e, te_e}, rd);
        tno++;
        $display("test %0d done", tno);
    endtask

    // Reference counters, loaded at each frame start
    always @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            {te_e, td_e, td_chk, re_e, ro_e, vld_e, rp_e} <= '0;
            alt = 1'b1;
        end else begin
            vld_e <= 1'b0;
            if (en) begin
                if (sof) begin
                    {tc, rc, tg, ta, rg, ra} = {tsh_c, rsh_c, tsh_g, tsh_a, rsh_g, rsh_a};
                    tp = 13'h0;
                    rp = 13'h0;
                end
                tgen = tc[0] & ~lo & ((tp < ta) ^ tc[1]);
                rgen = rc[0] & ~lo & ((rp < ra) ^ rc[1]);
                tov = tc[0] ? tgen : toe;
                rov = rc[0] ? rgen : roe;
                s = (tc[3:2] == 2'h0) ? 1'b0 : (tc[3:2] == 2'h1) ? 1'b1 :
                    (tc[3:2] == 2'h2) ? alt : tob;
                te_e <= tgen;
                re_e <= rgen;
                td_chk <= ~lo;
                td_e <= tov ? s : tpay;
                if (tov & ~lo)
                    alt = ~alt;
                if (rov)
                    ro_e <= rsd;
                if (~lo & ~rov) begin
                    vld_e <= 1'b1;
                    rp_e <= rsd;
                end
                if (~lo) begin
                    tp = (tp + 13'h1 == tg) ? 13'h0 : tp + 13'h1;
                    rp = (rp + 13'h1 == rg) ? 13'h0 : rp + 13'h1;
                end
            end
        end
    end

    always @(negedge ref_clk_in) begin
        if (chk_on) begin
            chk1("tx_ovh_enable_out", te_e, tx_ovh_enable_out);
            if (td_chk)
                chk1("tx_data_out", td_e, tx_data_out);
            chk1("rx_ovh_enable_out", re_e, rx_ovh_enable_out);
            chk1("rx_serial_ovh_out", ro_e, rx_serial_ovh_out);
            chk1("rx_payload_valid_out", vld_e, rx_payload_valid_out);
            if (vld_e)
                chk1("rx_payload_out", rp_e, rx_payload_out);
        end
    end

    initial begin
        ref_clk_in = 1'b0;
        forever #50 ref_clk_in = ~ref_clk_in;
    end

    initial begin
        {reset_in, psel, penable, pwrite, run, slow, chk_on} = 7'h40;
        {paddr, pwdata, failures, n_tests, tno} = '0;
        {tsh_c, rsh_c, tsh_g, tsh_a, rsh_g, rsh_a} = '0;
        repeat (20) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        chk_on <= 1'b1;
        @(posedge ref_clk_in);
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, ofs[i], 32'h0);
            chk32("reset value", (i == 2 || i == 4) ? 32'h8 : 32'h0, rd);
        end
        apb(1'b0, 32'h0000_0040, 32'h0);
        chk32("unmapped read", frac_pkg::BAD_ADDR_DATA, rd);
        chk1("unmapped error", 1'b1, err);
        apb(1'b1, frac_pkg::TX_GROUP_OFS, 32'h0);
        apb(1'b0, frac_pkg::TX_GROUP_OFS, 32'h0);
        chk32("zero group ignored", {19'h0, frac_pkg::GROUP_RST}, rd);
        tno++;
        $display("test %0d done", tno);
        run_cfg(4'h9, 4'h1, 13'h5, 13'h2, 13'h5, 13'h2, 1'b0);
        run_cfg(4'h7, 4'h3, 13'h4, 13'h1, 13'h6, 13'h4, 1'b1);
        run_cfg(4'h1, 4'h1, 13'h3, 13'h1fff, 13'h1, 13'h0, 1'b0);
        run_cfg(4'hf, 4'h3, 13'h1fff, 13'ha, 13'h1fff, 13'h0, 1'b0);
        run_cfg(4'hc, 4'h0, 13'h7, 13'h3, 13'h7, 13'h3, 1'b1);
        finish_test();
    end
endmodule // fractional_payload_controller_tb
`default_nettype wire
